// ### dei_defs.vh
`ifndef DEI_DEFS_VH
`define DEI_DEFS_VH

// register offsets
`define DEI_ADDR_OUT_CTRL   8'hE0
`define DEI_ADDR_MASK       8'hE1
`define DEI_ADDR_STATUS     8'hE5

// field positions
`define DEI_BIT_OUT_EN      0
`define DEI_BIT_SYNC        7
`define DEI_BIT_CRC         6
`define DEI_BIT_ECC_FATAL   5
`define DEI_BIT_ECC_FIXED   4
`define DEI_BIT_PROTOCOL    3
`define DEI_BIT_LEADER      2
`define DEI_BIT_PLL_LOST    0

// reset values
`define DEI_RST_OUT_CTRL    8'h00
`define DEI_RST_MASK        8'h00
`define DEI_RST_STATUS      8'h01

// implemented bits of status and mask
`define DEI_IMPL_BITS       8'hFD

`endif

// ### dei_error_irq.v
// What this block does
// [RQ1] with output enable 0 (reset value) the interrupt pin is not driven
// [RQ2] with output enable 1, pin high when any flag and its mask are set
// [RQ3] mask bit matches flag position; 0 masks, 1 enables; resets to 0
// [RQ4] flag bit 7 sets on unexpected horizontal or vertical sync packet
// [RQ5] flag bit 6 sets on payload crc mismatch
// [RQ6] flag bit 5 sets on uncorrectable header ecc error
// [RQ7] flag bit 4 sets on corrected header ecc error
// [RQ8] flag bit 3 sets on any low-level link protocol error
// [RQ9] flag bit 2 sets on leader sequence bit error
// [RQ10] flag bit 0 sets when pll lock goes from locked to unlocked
// [RQ11] pll lost flag resets to 1, other flags reset to 0
// [RQ12] flags stay set until software writes 1 to that position
// [RQ13] flags ignore mask; writing 0 keeps; event beats simultaneous clear
`include "dei_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module dei_error_irq #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input  wire              clk,
  input  wire              srst,
  // register port
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [DATA_W-1:0] reg_rdata,
  // events from the packet processor, one-cycle pulses, plus the pll lock level
  input  wire              unexpected_sync_evt,
  input  wire              payload_crc_evt,
  input  wire              header_ecc_fatal_evt,
  input  wire              header_ecc_fixed_evt,
  input  wire              link_protocol_evt,
  input  wire              leader_sequence_evt,
  input  wire              pll_locked,
  // interrupt pin as output and enable
  output reg               irq_out,
  output reg               irq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg  [DATA_W-1:0] out_ctrl_ff;
  reg  [DATA_W-1:0] mask_ff;
  reg  [DATA_W-1:0] flags_ff;
  reg  [DATA_W-1:0] nxt_flags;
  reg  [DATA_W-1:0] events;
  wire              lock_lost_pulse;

  // one decode used for both read and write paths
  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  dei_lock_edge u_lock_edge (
    .clk             (clk),
    .srst            (srst),
    .pll_locked      (pll_locked),
    .lock_lost_pulse (lock_lost_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event vector, one bit per flag position

  always @* begin
    events                     = {DATA_W{1'b0}};
    events[`DEI_BIT_SYNC]      = unexpected_sync_evt;   // see [RQ4]
    events[`DEI_BIT_CRC]       = payload_crc_evt;       // see [RQ5]
    events[`DEI_BIT_ECC_FATAL] = header_ecc_fatal_evt;  // see [RQ6]
    events[`DEI_BIT_ECC_FIXED] = header_ecc_fixed_evt;  // see [RQ7]
    events[`DEI_BIT_PROTOCOL]  = link_protocol_evt;     // see [RQ8]
    events[`DEI_BIT_LEADER]    = leader_sequence_evt;   // see [RQ9]
    events[`DEI_BIT_PLL_LOST]  = lock_lost_pulse;       // see [RQ10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: clear by writing ones, a same-cycle event wins

  always @* begin
    nxt_flags = flags_ff;
    if (reg_wr && hit(reg_addr, `DEI_ADDR_STATUS)) begin
      nxt_flags = flags_ff & ~reg_wdata;                // see [RQ12]
    end
    // mask is not consulted here on purpose
    nxt_flags = (nxt_flags | events) & `DEI_IMPL_BITS;  // see [RQ13]
  end

  always @(posedge clk) begin
    if (srst) begin
      flags_ff    <= `DEI_RST_STATUS;                   // see [RQ11]
      mask_ff     <= `DEI_RST_MASK;                     // see [RQ3]
      out_ctrl_ff <= `DEI_RST_OUT_CTRL;                 // see [RQ1]
    end else begin
      flags_ff <= nxt_flags;
      if (reg_wr && hit(reg_addr, `DEI_ADDR_MASK)) begin
        mask_ff <= reg_wdata & `DEI_IMPL_BITS;          // see [RQ3]
      end
      if (reg_wr && hit(reg_addr, `DEI_ADDR_OUT_CTRL)) begin
        out_ctrl_ff <= reg_wdata & 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero otherwise

  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, `DEI_ADDR_OUT_CTRL)) begin
        reg_rdata <= out_ctrl_ff;
      end else if (hit(reg_addr, `DEI_ADDR_MASK)) begin
        reg_rdata <= mask_ff;
      end else if (hit(reg_addr, `DEI_ADDR_STATUS)) begin
        reg_rdata <= flags_ff;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin; computed from next state so pin tracks registers exactly

  always @(posedge clk) begin
    if (srst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      // pin drives high or low when enabled; when released the board decides level
      irq_oe  <= (reg_wr && hit(reg_addr, `DEI_ADDR_OUT_CTRL)) ?
                 reg_wdata[`DEI_BIT_OUT_EN] :
                 out_ctrl_ff[`DEI_BIT_OUT_EN];          // see [RQ1]
      irq_out <= |(nxt_flags &
                 ((reg_wr && hit(reg_addr, `DEI_ADDR_MASK)) ?
                  reg_wdata : mask_ff));                 // see [RQ2]
    end
  end

endmodule // dei_error_irq

`default_nettype wire

// ### dei_error_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dei_error_irq_monitor (
  input wire logic clk, srst, reg_wr, reg_rd, pll_locked, irq_out, irq_oe,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic unexpected_sync_evt, payload_crc_evt, header_ecc_fatal_evt,
  input wire logic header_ecc_fixed_evt, link_protocol_evt, leader_sequence_evt
);
  wire [7:0] ev = {unexpected_sync_evt, payload_crc_evt, header_ecc_fatal_evt,
    header_ecc_fixed_evt, link_protocol_evt, leader_sequence_evt, 2'b00};
  wire       rs = reg_rd && reg_addr == 8'hE5;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst_pin; $past(srst) |-> !irq_oe && !irq_out; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin");
  property p_oe; reg_wr && reg_addr == 8'hE0 |=> irq_oe == $past(reg_wdata[0]);
  endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_evt; |ev ##1 rs |=> (reg_rdata & $past(ev, 2)) == $past(ev, 2);
  endproperty
  a_evt: assert property (p_evt) else $error("evt");
  property p_pll; $fell(pll_locked) ##2 rs |=> reg_rdata[0]; endproperty
  a_pll: assert property (p_pll) else $error("pll");
  property p_rstf; $past(srst) && rs && ev == 0 |=> reg_rdata == 8'h01;
  endproperty
  a_rstf: assert property (p_rstf) else $error("rst");
  property p_w1c; reg_wr && reg_addr == 8'hE5 && ev == 0 ##1 ev == 0 ##1 rs
    |=> (reg_rdata & $past(reg_wdata, 3) & 8'hFC) == 0; endproperty
  a_w1c: assert property (p_w1c) else $error("w1c");
  property p_mask0; reg_wr && reg_addr == 8'hE1 && reg_wdata == 0 |=> !irq_out;
  endproperty
  a_mask0: assert property (p_mask0) else $error("mask");
  // a rise needs a cause: mask write, event, or lock lost two edges back
  property p_rise; $rose(irq_out) |-> $past(reg_wr && reg_addr == 8'hE1 || |ev)
    || $past(pll_locked, 3) && !$past(pll_locked, 2); endproperty
  a_rise: assert property (p_rise) else $error("rise");
  c_irq: cover property (irq_oe && irq_out);
  c_pll: cover property ($fell(pll_locked));
  c_clr: cover property (reg_wr && reg_addr == 8'hE5 && |ev);
endmodule // dei_error_irq_monitor
bind dei_error_irq dei_error_irq_monitor dei_error_irq_monitor_i (.*);
`default_nettype wire

// ### dei_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dei_host_model (
  input  wire logic       clk,
  input  wire logic [2:0] kind,
  output var  logic [6:0] evt
);
  // bit 6 is the lock level; kind 6 drops it for one cycle
  // so that each request makes exactly one lost-lock edge
  initial evt = 7'h40;
  always @(posedge clk) begin
    evt <= {kind != 3'd6, 6'h01 << kind};
  end
endmodule // dei_host_model
`default_nettype wire

// ### dei_lock_edge.v
`timescale 1ns/1ps
`default_nettype none

// pulses once when the lock indicator falls from locked to unlocked
module dei_lock_edge (
  input  wire clk,
  input  wire srst,
  input  wire pll_locked,
  output wire lock_lost_pulse
);

  reg prev_locked_ff;

  always @(posedge clk) begin
    if (srst) begin
      prev_locked_ff <= 1'b0;
    end else begin
      prev_locked_ff <= pll_locked;
    end
  end

  assign lock_lost_pulse = prev_locked_ff & ~pll_locked;

endmodule // dei_lock_edge

`default_nettype wire

// ### tb_dei_error_irq.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_dei_error_irq;
  logic       clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, m, e, exp_q[$];
  logic [2:0] kind = 3'd7;
  wire  [7:0] reg_rdata;
  wire        unexpected_sync_evt, payload_crc_evt, header_ecc_fatal_evt,
              header_ecc_fixed_evt, link_protocol_evt, leader_sequence_evt,
              pll_locked, irq_out, irq_oe;
  int         miscompares = 0, comparisons = 0, seed = 34, k;
  dei_error_irq dei_error_irq_i (.*);
  dei_host_model dei_host_model_i (.clk, .kind, .evt({pll_locked,
    unexpected_sync_evt, payload_crc_evt, header_ecc_fatal_evt,
    header_ecc_fixed_evt, link_protocol_evt, leader_sequence_evt}));
  initial forever #50 clk = ~clk;
  task close_out;
    $display("checks %0d errors %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // two cycles per access, strobe then idle; a read notes its expected data in the queue
  task bus(input logic w, input logic [7:0] a, d);
    if (!w) exp_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk) {reg_wr, reg_rd} <= 2'b00;
    @(posedge clk);
  endtask
  task ev(input logic [2:0] t);
    kind <= t;
    @(posedge clk) kind <= 3'd7;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, reg_rdata)
    end
    rd_d <= reg_rd;
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 8'hE5, 8'h01);
    bus(1'b0, 8'hE1, 8'h00);
    bus(1'b0, 8'hE0, 8'h00);
    bus(1'b1, 8'hE5, 8'h00);
    bus(1'b0, 8'hE5, 8'h01);
    bus(1'b1, 8'hE5, 8'hFF);
    bus(1'b0, 8'hE5, 8'h00);
    for (k = 0; k < 6; k++) begin
      ev(k[2:0]);
      bus(1'b0, 8'hE5, 8'h04 << k);
      bus(1'b1, 8'hE5, 8'h04 << k);
    end
    ev(3'd6);
    @(posedge clk);
    bus(1'b0, 8'hE5, 8'h01);
    m = 8'($random(seed));
    bus(1'b1, 8'hE0, 8'h01);
    bus(1'b1, 8'hE1, m);
    #1 `CHK("irq", m[0], irq_out)
    `CHK("oe", 1'b1, irq_oe)
    ev(3'd1);
    #1 `CHK("irq", m[0] | m[3], irq_out)
    fork
      ev(3'd4);
      #100 bus(1'b1, 8'hE5, 8'hFF);
    join
    bus(1'b0, 8'hE5, 8'h40);
    bus(1'b1, 8'hE1, 8'h00);
    #1 `CHK("irq", 1'b0, irq_out)
    close_out();
  end
endmodule // tb_dei_error_irq
`default_nettype wire
